/* File: pkg/prf_pkg.sv */
// Package with the register map, field layouts and reset values of the profile register bank.
package prf_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [4:0] PRF_ADDR_CONTROL_FUNCTION_ONE = 5'h00;
    localparam logic [4:0] PRF_ADDR_PROFILE_SLOT_SIX = 5'h0c;
    localparam logic [4:0] PRF_ADDR_PROFILE_SLOT_SEVEN = 5'h0d;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int PRF_FTW_W = 48;
    localparam int PRF_POW_W = 14;
    localparam int PRF_FTW_LSB = 0;
    localparam int PRF_POW_LSB = 48;
    localparam int PRF_REG_W = 64;
    localparam int PRF_CFR_W = 32;
    localparam int PRF_UNLOCK_BIT = 24;
    localparam int PRF_NUM_SLOTS = 2;
    localparam logic [3:0] PRF_CFR_FULL_BE = 4'hf;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PRF_FTW_W-1:0] PRF_FTW_RST = 48'h0;
    localparam logic [PRF_POW_W-1:0] PRF_POW_RST = 14'h0;
    localparam logic [PRF_REG_W-1:0] PRF_RDATA_RST = 64'h0;
endpackage : prf_pkg

/* File: pkg/prf_flag_if.sv */
// Interface between the register bank and its unlock flag and shared pin logic.
`timescale 1ns/1ps
interface prf_flag_if;
    logic sync_mode;
    logic pfd_unlock;
    logic lock_pin;
    logic clr;
    logic flag;
    logic sync_in;
    logic lock_det;

    modport bank (
        output sync_mode,
        output pfd_unlock,
        output lock_pin,
        output clr,
        input flag,
        input sync_in,
        input lock_det
    );
    modport flagger (
        input sync_mode,
        input pfd_unlock,
        input lock_pin,
        input clr,
        output flag,
        output sync_in,
        output lock_det
    );
endinterface : prf_flag_if

/* File: design/prf_unlock_flag.sv */
// Sticky unlock flag and routing of the shared lock indicator pin.
`timescale 1ns/1ps
module prf_unlock_flag
    import prf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    prf_flag_if.flagger fl
);
    logic flag_r;
    logic flag_nxt;
    logic sync_in_r;
    logic sync_in_nxt;
    logic lock_det_r;
    logic lock_det_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        flag_nxt = flag_r;
        if (fl.clr) begin
            flag_nxt = 1'b0;
        end
        if (fl.sync_mode && fl.pfd_unlock) begin
            flag_nxt = 1'b1;
        end
        sync_in_nxt = fl.sync_mode ? fl.lock_pin : 1'b0;
        lock_det_nxt = fl.sync_mode ? 1'b0 : fl.lock_pin;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flag_r <= 1'b0;
            sync_in_r <= 1'b0;
            lock_det_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            sync_in_r <= sync_in_nxt;
            lock_det_r <= lock_det_nxt;
        end
    end

    assign fl.flag = flag_r;
    assign fl.sync_in = sync_in_r;
    assign fl.lock_det = lock_det_r;
endmodule : prf_unlock_flag

/* File: design/prf_profile_regs.sv */
// Register bank for profile slots six and seven and the unlock flag of the first control register.
`timescale 1ns/1ps
module prf_profile_regs
    import prf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wr_be,
    input wire logic [PRF_REG_W-1:0] i_wdata,
    input wire logic i_auto_sync,
    input wire logic i_hw_sync,
    input wire logic i_pfd_unlock,
    input wire logic i_lock_pin,
    output logic [PRF_REG_W-1:0] o_rdata,
    output logic o_rd_valid,
    output logic [PRF_FTW_W-1:0] o_freq_tuning_word_six,
    output logic [PRF_POW_W-1:0] o_phase_offset_word_six,
    output logic [PRF_FTW_W-1:0] o_freq_tuning_word_seven,
    output logic [PRF_POW_W-1:0] o_phase_offset_word_seven,
    output logic o_sync_in,
    output logic o_lock_det
);
    logic [PRF_FTW_W-1:0] ftw_r [PRF_NUM_SLOTS];
    logic [PRF_FTW_W-1:0] ftw_nxt [PRF_NUM_SLOTS];
    logic [PRF_POW_W-1:0] pow_r [PRF_NUM_SLOTS];
    logic [PRF_POW_W-1:0] pow_nxt [PRF_NUM_SLOTS];
    logic [PRF_REG_W-1:0] rdata_r;
    logic [PRF_REG_W-1:0] rdata_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic [PRF_REG_W-1:0] slot_word [PRF_NUM_SLOTS];
    logic [7:0] slot_we [PRF_NUM_SLOTS];
    logic [PRF_NUM_SLOTS-1:0] slot_sel;
    logic cfr_sel;
    logic cfr_rd;
    logic [PRF_REG_W-1:0] cfr_word;

    prf_flag_if fl ();

    prf_unlock_flag prf_unlock_flag_i (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .fl(fl.flagger)
    );

    // ------------------------------------------------------------
    // Unlock flag and pin routing
    // ------------------------------------------------------------
    // either sync mode claims the pin
    assign fl.sync_mode = i_auto_sync | i_hw_sync;
    assign fl.pfd_unlock = i_pfd_unlock;
    assign fl.lock_pin = i_lock_pin;
    assign cfr_rd = i_rd_en && cfr_sel;
    assign fl.clr = cfr_rd;
    // flag in bit 24, rest zero
    always_comb begin
        cfr_word = PRF_RDATA_RST;
        cfr_word[PRF_UNLOCK_BIT] = fl.flag;
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Control writes are decoded but hold no storage in this bank.
    // one select per register
    always_comb begin
        slot_sel = '0;
        cfr_sel = 1'b0;
        if (i_addr == PRF_ADDR_PROFILE_SLOT_SIX) begin
            slot_sel[0] = 1'b1;
        end else if (i_addr == PRF_ADDR_PROFILE_SLOT_SEVEN) begin
            slot_sel[1] = 1'b1;
        end else if (i_addr == PRF_ADDR_CONTROL_FUNCTION_ONE) begin
            cfr_sel = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Profile slot storage
    // ------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < PRF_NUM_SLOTS; s++) begin : g_slot
            assign slot_we[s] = (i_wr_en && slot_sel[s]) ? i_wr_be : 8'h00;
            assign slot_word[s] = {2'b00, pow_r[s], ftw_r[s]};
            always_comb begin
                ftw_nxt[s] = ftw_r[s];
                pow_nxt[s] = pow_r[s];
                for (int b = 0; b < 6; b++) begin
                    if (slot_we[s][b]) begin
                        ftw_nxt[s][8*b +: 8] = i_wdata[PRF_FTW_LSB + 8*b +: 8];
                    end
                end
                if (slot_we[s][6]) begin
                    pow_nxt[s][7:0] = i_wdata[PRF_POW_LSB +: 8];
                end
                if (slot_we[s][7]) begin
                    pow_nxt[s][13:8] = i_wdata[PRF_POW_LSB + 8 +: 6];
                end
            end
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    ftw_r[s] <= PRF_FTW_RST;
                    pow_r[s] <= PRF_POW_RST;
                end else begin
                    ftw_r[s] <= ftw_nxt[s];
                    pow_r[s] <= pow_nxt[s];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        rd_valid_nxt = i_rd_en;
        if (i_rd_en) begin
            if (slot_sel[0]) begin
                rdata_nxt = slot_word[0];
            end else if (slot_sel[1]) begin
                rdata_nxt = slot_word[1];
            end else if (cfr_sel) begin
                rdata_nxt = cfr_word;
            end else begin
                rdata_nxt = PRF_RDATA_RST;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_r <= PRF_RDATA_RST;
            rd_valid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_rd_valid = rd_valid_r;
    assign o_freq_tuning_word_six = ftw_r[0];
    assign o_phase_offset_word_six = pow_r[0];
    assign o_freq_tuning_word_seven = ftw_r[1];
    assign o_phase_offset_word_seven = pow_r[1];
    assign o_sync_in = fl.sync_in;
    assign o_lock_det = fl.lock_det;
endmodule : prf_profile_regs

/* File: sim/prf_profile_regs_sva.sv */
// Assertions on the ports of the profile register bank.
`timescale 1ns/1ps
module prf_profile_regs_sva
    import prf_pkg::*;
(
    input wire logic i_clk, i_arst_n, i_wr_en, i_rd_en, i_auto_sync, i_hw_sync,
    input wire logic i_pfd_unlock, i_lock_pin, o_rd_valid, o_sync_in, o_lock_det,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wr_be,
    input wire logic [PRF_REG_W-1:0] i_wdata, o_rdata,
    input wire logic [PRF_FTW_W-1:0] o_freq_tuning_word_six,
    input wire logic [PRF_POW_W-1:0] o_phase_offset_word_six
);
    wire logic set_w = (i_auto_sync || i_hw_sync) && i_pfd_unlock;
    wire logic [PRF_FTW_W-1:0] wd_ftw = i_wdata[PRF_FTW_W-1:0];
    wire logic [PRF_POW_W-1:0] wd_pow = i_wdata[PRF_POW_LSB +: PRF_POW_W];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_ctl_rd;
        i_rd_en && i_addr == PRF_ADDR_CONTROL_FUNCTION_ONE;
    endsequence
    sequence s_six_wr;
        i_wr_en && i_addr == PRF_ADDR_PROFILE_SLOT_SIX && i_wr_be == 8'hff;
    endsequence
    a_ftw_store: assert property (
        s_six_wr |=> o_freq_tuning_word_six == $past(wd_ftw)) else $error("bad ftw");
    a_pow_store: assert property (
        s_six_wr |=> o_phase_offset_word_six == $past(wd_pow)) else $error("bad pow");
    a_slot_read: assert property (
        i_rd_en && i_addr == PRF_ADDR_PROFILE_SLOT_SIX |=> o_rd_valid && o_rdata == {2'h0,
        $past(o_phase_offset_word_six), $past(o_freq_tuning_word_six)}) else $error("bad read");
    a_reset_zero: assert property (
        $rose(i_arst_n) |-> {o_phase_offset_word_six, o_freq_tuning_word_six} == 62'h0)
        else $error("slot not zero");
    a_pin_route: assert property (
        i_auto_sync || i_hw_sync |=> o_sync_in == $past(i_lock_pin) && !o_lock_det)
        else $error("bad pin");
    a_lock_route: assert property (
        !(i_auto_sync || i_hw_sync) |=> o_lock_det == $past(i_lock_pin) && !o_sync_in)
        else $error("bad lock pin");
    a_flag_set: assert property (
        set_w ##1 s_ctl_rd |=> o_rdata[PRF_UNLOCK_BIT]) else $error("flag not set");
    a_flag_clear: assert property (
        s_ctl_rd ##0 !set_w ##1 !set_w ##1 s_ctl_rd |=> !o_rdata[PRF_UNLOCK_BIT])
        else $error("flag stuck");
endmodule : prf_profile_regs_sva
bind prf_profile_regs prf_profile_regs_sva prf_profile_regs_sva_i (.*);

/* File: sim/prf_profile_regs_test.sv */
// Self-checking bench for the profile register bank.
`timescale 1ns/1ps
module prf_profile_regs_test
    import prf_pkg::*;
;
    localparam logic [4:0] SIX = PRF_ADDR_PROFILE_SLOT_SIX;
    localparam logic [4:0] SEV = PRF_ADDR_PROFILE_SLOT_SEVEN;
    localparam logic [4:0] CTL = PRF_ADDR_CONTROL_FUNCTION_ONE;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0, i_lock_pin = 1'b1;
    logic i_auto_sync = 1'b0, i_hw_sync = 1'b0, i_pfd_unlock = 1'b0;
    logic o_rd_valid, o_sync_in, o_lock_det;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wr_be = 8'h00;
    logic [63:0] i_wdata = 64'h0, o_rdata;
    logic [47:0] o_freq_tuning_word_six, o_freq_tuning_word_seven;
    logic [13:0] o_phase_offset_word_six, o_phase_offset_word_seven;
    int errors = 0, n_tests = 0;
    always #2 i_clk = ~i_clk;
    prf_profile_regs prf_profile_regs_i (.*);
    task automatic chk(input logic [64:0] got, input logic [64:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk
    task automatic finish_test();
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // A write stores the bytes of d enabled by be; a read expects d back with the valid pulse.
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] be,
            input logic [63:0] d);
        @(posedge i_clk);
        #1;
        {i_wr_en, i_rd_en, i_addr, i_wr_be, i_wdata} = {w, !w, a, be, d};
        @(posedge i_clk);
        #1;
        {i_wr_en, i_rd_en} = 2'b00;
        if (!w) chk({o_rd_valid, o_rdata}, {1'b1, d});
    endtask : bus
    task automatic t_slots();
        bus(1'b0, SEV, 8'h00, 64'h0);
        bus(1'b1, SEV, 8'hc1, 64'h3fff_ffff_ffff_ffff);
        chk({o_phase_offset_word_seven, o_freq_tuning_word_seven}, 62'h3fff_0000_0000_00ff);
        bus(1'b0, SEV, 8'h00, 64'h3fff_0000_0000_00ff);
        bus(1'b1, SIX, 8'hff, 64'h2345_6789_abcd_ef01);
        chk({o_phase_offset_word_six, o_freq_tuning_word_six}, 62'h2345_6789_abcd_ef01);
        bus(1'b0, 5'h01, 8'h00, 64'h0);
        bus(1'b0, SIX, 8'h00, 64'h2345_6789_abcd_ef01);
    endtask : t_slots
    // Mid-run reset, held across a clock edge, must clear stored words and the read port.
    task automatic t_reset();
        i_arst_n = 1'b0;
        @(posedge i_clk);
        #1;
        chk({o_phase_offset_word_six, o_freq_tuning_word_six}, 65'h0);
        chk({o_phase_offset_word_seven, o_freq_tuning_word_seven}, 65'h0);
        chk({o_rd_valid, o_rdata}, 65'h0);
        i_arst_n = 1'b1;
        bus(1'b0, SIX, 8'h00, 64'h0);
        bus(1'b0, SEV, 8'h00, 64'h0);
    endtask : t_reset
    task automatic t_flag();
        bus(1'b1, CTL, 8'h0f, 64'h0100_0000);
        bus(1'b0, CTL, 8'h00, 64'h0);
        i_pfd_unlock = 1'b1;
        bus(1'b0, CTL, 8'h00, 64'h0);
        i_hw_sync = 1'b1;
        bus(1'b0, CTL, 8'h00, 64'h0100_0000);
        chk({63'h0, o_sync_in, o_lock_det}, 65'h2);
        {i_hw_sync, i_pfd_unlock} = 2'b00;
        bus(1'b0, CTL, 8'h00, 64'h0100_0000);
        bus(1'b0, CTL, 8'h00, 64'h0);
        {i_auto_sync, i_lock_pin} = 2'b10;
        bus(1'b0, CTL, 8'h00, 64'h0);
        chk({63'h0, o_sync_in, o_lock_det}, 65'h0);
        {i_lock_pin, i_pfd_unlock} = 2'b11;
        bus(1'b0, CTL, 8'h00, 64'h0100_0000);
        chk({63'h0, o_sync_in, o_lock_det}, 65'h2);
        {i_auto_sync, i_pfd_unlock} = 2'b00;
        bus(1'b0, CTL, 8'h00, 64'h0100_0000);
        bus(1'b0, CTL, 8'h00, 64'h0);
        chk({63'h0, o_sync_in, o_lock_det}, 65'h1);
        i_lock_pin = 1'b0;
        bus(1'b0, CTL, 8'h00, 64'h0);
        chk({63'h0, o_sync_in, o_lock_det}, 65'h0);
    endtask : t_flag
    initial begin
        repeat (6) @(posedge i_clk);
        #1;
        i_arst_n = 1'b1;
        t_slots();
        t_reset();
        t_flag();
        finish_test();
    end
endmodule : prf_profile_regs_test
